// ### tb/code_mem_model.sv
// Behavioural code and data memory that answers the decoder's fetches.
`timescale 1ns/1ps
`default_nettype none
module code_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Fetch port
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_ack,
  output logic      [7:0]  mem_rdata,
  // Wait cycles before each answer
  input  wire logic [1:0]  slow
);
  logic [7:0] mem [0:65535];
  logic [1:0] wait_cnt;
  logic [1:0] next_wait_cnt;
  logic [7:0] last;
  logic [7:0] next_last;
  // Between answers the data lines show the inverse of the last byte, so a
  // sample taken outside an answer never repeats the byte last handed out.
  always_comb begin
    mem_ack       = mem_req && (wait_cnt == slow);
    mem_rdata     = mem_ack ? mem[mem_addr] : ~last;
    next_wait_cnt = (mem_req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
    next_last     = mem_ack ? mem[mem_addr] : last;
  end
  // Wait counter and last byte handed out.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_cnt <= 2'h0;
      last     <= 8'h00;
    end else begin
      wait_cnt <= next_wait_cnt;
      last     <= next_last;
    end
  end
endmodule
`default_nettype wire

// ### tb/cpu_operand_address_decoder_chk.sv
// Port checker of the operand address decoder.
`timescale 1ns/1ps
`default_nettype none
module cpu_operand_address_decoder_chk (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    sys_rst,
  // Index registers
  input wire logic [7:0]              x_index,
  input wire logic [7:0]              y_index,
  // Memory port
  input wire logic                    mem_req,
  input wire logic                    mem_ack,
  // Results
  input wire logic                    done,
  input wire opaddr_pkg::addr_mode_e  mode,
  input wire opaddr_pkg::mode_class_e mode_class,
  input wire logic [15:0]             eff_addr,
  input wire logic [7:0]              operand,
  input wire logic [15:0]             next_pc_out,
  input wire logic [1:0]              operand_bytes,
  input wire logic                    illegal_reset
);
  // ===========================================================================
  // Results are judged in the one cycle where done stands; the illegal code pulse is judged whenever it stands.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  inh_len_a:
    assert property (done && mode == opaddr_pkg::M_INHERENT |->
      operand_bytes == 2'h0 && mode_class == opaddr_pkg::CLS_INHERENT)
    else $error("Inherent form fetched operand bytes.");
  imm_len_a:
    assert property (done && mode == opaddr_pkg::M_IMMEDIATE |->
      operand_bytes == 2'h1 && mode_class == opaddr_pkg::CLS_IMMEDIATE)
    else $error("Immediate form length wrong.");
  dir_short_a:
    assert property (done && mode == opaddr_pkg::M_DIR_SHORT |->
      eff_addr == {8'h00, operand} && operand_bytes == 2'h1)
    else $error("Short direct address wrong.");
  dir_long_a:
    assert property (done && mode == opaddr_pkg::M_DIR_LONG |->
      operand_bytes == 2'h2 && mode_class == opaddr_pkg::CLS_DIRECT)
    else $error("Long direct length wrong.");
  idx_none_a:
    assert property (done && mode == opaddr_pkg::M_IDX_NONE |->
      operand_bytes == 2'h0 && (eff_addr == {8'h00, x_index} ||
      eff_addr == {8'h00, y_index}))
    else $error("No-offset indexed address wrong.");
  idx_short_a:
    assert property (done && mode == opaddr_pkg::M_IDX_SHORT |->
      eff_addr == {8'h00, operand} + {8'h00, x_index} ||
      eff_addr == {8'h00, operand} + {8'h00, y_index})
    else $error("Short indexed sum wrong.");
  ind_page_a:
    assert property (done && mode == opaddr_pkg::M_IND_SHORT |->
      eff_addr <= opaddr_pkg::PAGE_ZERO_LAST && operand_bytes == 2'h1)
    else $error("Short indirect left page zero.");
  rel_target_a:
    assert property (done && mode == opaddr_pkg::M_REL_DIRECT |->
      eff_addr == next_pc_out + {{8{operand[7]}}, operand})
    else $error("Relative target wrong.");
  bad_code_a:
    assert property (illegal_reset |-> !done ##1 !illegal_reset)
    else $error("Illegal code pulse wrong.");

  // Main scenarios reached.
  cover property (done && mode == opaddr_pkg::M_IND_LONG);
  cover property (illegal_reset);
  cover property (mem_req && !mem_ack);
endmodule

bind cpu_operand_address_decoder cpu_operand_address_decoder_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .x_index(x_index), .y_index(y_index),
  .mem_req(mem_req), .mem_ack(mem_ack), .done(done), .mode(mode),
  .mode_class(mode_class), .eff_addr(eff_addr), .operand(operand),
  .next_pc_out(next_pc_out), .operand_bytes(operand_bytes),
  .illegal_reset(illegal_reset)
);
`default_nettype wire

// ### tb/cpu_operand_address_decoder_tb.sv
// Self-checking testbench of the operand address decoder.
`timescale 1ns/1ps
`default_nettype none
module cpu_operand_address_decoder_tb;
  // One table row: prefix, opcode, two following bytes, expected results.
  typedef struct {
    logic [7:0]             pf;
    logic [7:0]             op;
    logic [7:0]             a1;
    logic [7:0]             a2;
    opaddr_pkg::addr_mode_e md;
    logic [15:0]            ea;
    logic [1:0]             nb;
  } row_s;
  localparam logic [15:0] PC0 = 16'h1200;
  logic clk, sys_rst, start, mem_req, mem_ack, done, illegal_reset;
  logic [15:0] pc, mem_addr, eff_addr, next_pc_out;
  logic [7:0]  x_index, y_index, mem_rdata, opcode, operand;
  logic [1:0]  operand_bytes, slow;
  opaddr_pkg::addr_mode_e  mode;
  opaddr_pkg::mode_class_e mode_class;
  int   bad_count = 0;
  int   cmp_count = 0;
  row_s r;
  // An expected address of zero means the address is not judged.
  row_s rows [18] = '{
    '{8'h00, 8'ha6, 8'h55, 8'h00, opaddr_pkg::M_IMMEDIATE, 16'h0000, 2'h1},
    '{8'h00, 8'hb6, 8'h55, 8'h00, opaddr_pkg::M_DIR_SHORT, 16'h0055, 2'h1},
    '{8'h00, 8'hc6, 8'h12, 8'h34, opaddr_pkg::M_DIR_LONG, 16'h1234, 2'h2},
    '{8'h00, 8'hf6, 8'h00, 8'h00, opaddr_pkg::M_IDX_NONE, 16'h00ff, 2'h0},
    '{8'h00, 8'he6, 8'hff, 8'h00, opaddr_pkg::M_IDX_SHORT, 16'h01fe, 2'h1},
    '{8'h00, 8'hd6, 8'h12, 8'h00, opaddr_pkg::M_IDX_LONG, 16'h12ff, 2'h2},
    '{8'h90, 8'hf6, 8'h00, 8'h00, opaddr_pkg::M_IDX_NONE, 16'h0056, 2'h0},
    '{8'h92, 8'hb6, 8'h40, 8'h00, opaddr_pkg::M_IND_SHORT, 16'h0012, 2'h1},
    '{8'h92, 8'hc6, 8'h40, 8'h00, opaddr_pkg::M_IND_LONG, 16'h129a, 2'h1},
    '{8'h92, 8'he6, 8'h40, 8'h00, opaddr_pkg::M_INDIDX_SHORT, 16'h0111, 2'h1},
    '{8'h91, 8'hd6, 8'h40, 8'h00, opaddr_pkg::M_INDIDX_LONG, 16'h12f0, 2'h1},
    '{8'h91, 8'hb6, 8'h55, 8'h00, opaddr_pkg::M_DIR_SHORT, 16'h0055, 2'h1},
    '{8'h00, 8'h20, 8'h05, 8'h00, opaddr_pkg::M_REL_DIRECT, 16'h1207, 2'h1},
    '{8'h00, 8'h20, 8'hf0, 8'h00, opaddr_pkg::M_REL_DIRECT, 16'h11f2, 2'h1},
    '{8'h92, 8'h20, 8'h40, 8'h00, opaddr_pkg::M_REL_INDIRECT, 16'h1215, 2'h1},
    '{8'h00, 8'h4c, 8'h00, 8'h00, opaddr_pkg::M_INHERENT, 16'h0000, 2'h0},
    '{8'h00, 8'h3c, 8'h21, 8'h00, opaddr_pkg::M_DIR_SHORT, 16'h0021, 2'h1},
    '{8'h00, 8'h14, 8'h33, 8'h00, opaddr_pkg::M_BIT_DIRECT, 16'h0033, 2'h1}
  };

  cpu_operand_address_decoder u_dut (
    .clk(clk), .sys_rst(sys_rst), .start(start), .pc(pc),
    .x_index(x_index), .y_index(y_index), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .done(done), .opcode(opcode), .mode(mode), .mode_class(mode_class),
    .eff_addr(eff_addr), .operand(operand), .next_pc_out(next_pc_out),
    .operand_bytes(operand_bytes), .illegal_reset(illegal_reset)
  );
  code_mem_model u_mem (
    .clk(clk), .sys_rst(sys_rst), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow)
  );

  // ===========================================================================
  // Comparison, stimulus and closing tasks.
  task automatic chk_addr(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_small(input logic [7:0] got, input logic [7:0] exp);
    chk_addr({8'h00, got}, {8'h00, exp});
  endtask
  // Loads the code, then holds start for 1 + hold cycles; while held the
  // pc input moves away so a second take would show in the results.
  task automatic launch(input logic [7:0] pf, op, a1, a2,
                        input logic [1:0] wt, input int hold);
    logic [15:0] p;
    p = PC0 + 16'(pf != 8'h00);
    u_mem.mem[PC0] = pf;
    u_mem.mem[p] = op;
    u_mem.mem[p + 16'h1] = a1;
    u_mem.mem[p + 16'h2] = a2;
    slow = wt;
    @(posedge clk);
    #1;
    start = 1'b1;
    pc = PC0;
    repeat (hold + 1) begin
      @(posedge clk);
      #1;
      pc = 16'h3000;
    end
    start = 1'b0;
  endtask
  task automatic wait_end();
    for (int n = 0; n < 60; n++) begin
      if (done === 1'b1 || illegal_reset === 1'b1) break;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Clock of 50 ns.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // A hang is cut short well beyond the fewer than two hundred cycles of the run.
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
  // Main sequence.
  initial begin
    sys_rst = 1'b1;
    start = 1'b0;
    pc = 16'h0000;
    x_index = 8'hff;
    y_index = 8'h56;
    slow = 2'h0;
    u_mem.mem[16'h0040] = 8'h12;
    u_mem.mem[16'h0041] = 8'h9a;
    repeat (6) @(posedge clk);
    #1;
    chk_small({5'h00, mem_req, done, illegal_reset}, 8'h00);
    sys_rst = 1'b0;
    // Table rows, with the memory answering after 0, 1 or 2 waits.
    foreach (rows[i]) begin
      r = rows[i];
      launch(r.pf, r.op, r.a1, r.a2, 2'(i % 3), 0);
      wait_end();
      chk_small({7'h00, done}, 8'h01);
      chk_small({3'h0, mode}, {3'h0, r.md});
      chk_small({6'h00, operand_bytes}, {6'h00, r.nb});
      chk_small(opcode, r.op);
      if (r.nb != 2'h0) chk_small(operand, r.a1);
      chk_addr(next_pc_out, PC0 + 16'(r.nb) + 16'h1 + 16'(r.pf != 8'h00));
      if (r.ea != 16'h0000) chk_addr(eff_addr, r.ea);
    end
    // An unknown code gives a one-cycle reset pulse and no result.
    launch(8'h00, 8'h95, 8'h00, 8'h00, 2'h1, 0);
    wait_end();
    chk_small({6'h00, illegal_reset, done}, 8'h02);
    @(posedge clk);
    #1;
    chk_small({7'h00, illegal_reset}, 8'h00);
    // Start held while busy with a moving pc is not taken again.
    launch(8'h00, 8'hb6, 8'h77, 8'h00, 2'h3, 3);
    wait_end();
    chk_addr(eff_addr, 16'h0077);
    chk_addr(next_pc_out, PC0 + 16'h2);
    // Reset in mid-fetch drops the request at once; decoding then resumes.
    launch(8'h00, 8'hc6, 8'h12, 8'h34, 2'h3, 0);
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b1;
    #1;
    chk_small({6'h00, mem_req, done}, 8'h00);
    @(posedge clk);
    #1;
    sys_rst = 1'b0;
    launch(8'h00, 8'hc6, 8'hab, 8'hcd, 2'h2, 0);
    wait_end();
    chk_addr(eff_addr, 16'habcd);
    finish_test();
  end
endmodule
`default_nettype wire

// ### verilog/cpu_operand_address_decoder.sv
// Operand address decoder: fetch sequencer and effective address former.
//
// Functional notes
// - Seventeen modes in seven classes supported
// - Long forms reach full 64 Kbyte space
// - Short direct and short indirect forms limited to page zero
// - Memory read-modify-write uses short forms only
// - Inherent is one byte, no operand
// - Immediate second byte is the value
// - Short direct: one address byte
// - Long direct: two-byte address word
// - Indexed address is index plus offset
// - No-offset indexed uses index register alone
// - Short indexed sums without wrap, to 1FE
// - Long indexed: word offset plus index
// - Short indirect: byte pointer in page zero
// - Long indirect: word pointer in page zero
// - Indirect indexed: pointer plus index
// - Relative adds signed 8-bit offset
// - Three prefixes retarget the next opcode
// - Unknown code resets; bad combination does not
`timescale 1ns/1ps
`default_nettype none
module cpu_operand_address_decoder (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Instruction start
  input  wire logic        start,
  input  wire logic [15:0] pc,
  // Index registers
  input  wire logic [7:0]  x_index,
  input  wire logic [7:0]  y_index,
  // Memory fetch port
  output logic             mem_req,
  output logic      [15:0] mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  // Decode results
  output logic             done,
  output logic      [7:0]  opcode,
  output opaddr_pkg::addr_mode_e mode,
  output opaddr_pkg::mode_class_e mode_class,
  output logic      [15:0] eff_addr,
  output logic      [7:0]  operand,
  output logic      [15:0] next_pc_out,
  output logic      [1:0]  operand_bytes,
  output logic             illegal_reset
);

  typedef enum logic [2:0] {
    S_IDLE, S_OPCODE, S_ARG1, S_ARG2, S_PTR_HI, S_PTR_LO, S_FINISH
  } state_e;

  state_e                  state, next_state;
  logic [15:0]             fetch_pc, next_fetch_pc;
  logic [15:0]             addr, next_addr;
  logic [15:0]             ptr, next_ptr;
  logic [7:0]              opc, next_opc;
  logic [7:0]              arg, next_arg;
  logic [1:0]              pfx, next_pfx;    // 0 none, 1 Y, 2 ind, 3 Y-ind
  logic [1:0]              nbytes, next_nbytes;
  logic                    rst_pulse, next_rst_pulse;
  opaddr_pkg::addr_mode_e  cls_mode, eff_mode;
  logic                    cls_legal, is_prefix;
  logic [15:0]             ea_sum;
  logic [15:0]             ea_base;
  logic                    use_y, use_idx;

  // ===========================================================================
  // Opcode classification.
  opcode_classifier u_classify (
    .opcode (opc),
    .mode   (cls_mode),
    .rmw    (),
    .legal  (cls_legal)
  );

  // Prefix detection looks at the raw fetched byte.
  assign is_prefix = (mem_rdata == opaddr_pkg::Y_INDEX_PREFIX) ||
                     (mem_rdata == opaddr_pkg::INDIRECT_PREFIX) ||
                     (mem_rdata == opaddr_pkg::Y_INDIRECT_INDEXED_PREFIX);

  // ===========================================================================
  // Prefix retargeting: direct becomes indirect, indexed becomes indirect
  // indexed. An odd pairing keeps the plain mode rather than resetting.
  always_comb begin
    eff_mode = cls_mode;
    if (pfx == 2'd2) begin
      case (cls_mode)
        opaddr_pkg::M_DIR_SHORT:   eff_mode = opaddr_pkg::M_IND_SHORT;
        opaddr_pkg::M_DIR_LONG:    eff_mode = opaddr_pkg::M_IND_LONG;
        opaddr_pkg::M_IDX_SHORT:   eff_mode = opaddr_pkg::M_INDIDX_SHORT;
        opaddr_pkg::M_IDX_LONG:    eff_mode = opaddr_pkg::M_INDIDX_LONG;
        opaddr_pkg::M_REL_DIRECT:  eff_mode = opaddr_pkg::M_REL_INDIRECT;
        opaddr_pkg::M_BIT_DIRECT:  eff_mode = opaddr_pkg::M_BIT_INDIRECT;
        opaddr_pkg::M_BIT_DIR_REL: eff_mode = opaddr_pkg::M_BIT_IND_REL;
        default:                   eff_mode = cls_mode;
      endcase
    end else if (pfx == 2'd3) begin
      // Only the X indirect indexed forms have a Y twin; a direct opcode
      // behind this prefix is an odd pairing and must stay direct.
      case (cls_mode)
        opaddr_pkg::M_IDX_SHORT:   eff_mode = opaddr_pkg::M_INDIDX_SHORT;
        opaddr_pkg::M_IDX_LONG:    eff_mode = opaddr_pkg::M_INDIDX_LONG;
        default:                   eff_mode = cls_mode;
      endcase
    end
  end

  // Y is selected by the Y prefix or the Y indirect indexed prefix.
  assign use_y = (pfx == 2'd1) || (pfx == 2'd3);

  // ===========================================================================
  // Effective address formation.
  always_comb begin
    ea_base = addr;
    use_idx = 1'b0;
    case (eff_mode)
      opaddr_pkg::M_IDX_NONE: begin
        ea_base = 16'h0000;
        use_idx = 1'b1;
      end
      opaddr_pkg::M_IDX_SHORT, opaddr_pkg::M_IDX_LONG: begin
        use_idx = 1'b1;
      end
      opaddr_pkg::M_INDIDX_SHORT, opaddr_pkg::M_INDIDX_LONG: begin
        ea_base = ptr;
        use_idx = 1'b1;
      end
      opaddr_pkg::M_IND_SHORT, opaddr_pkg::M_IND_LONG,
      opaddr_pkg::M_BIT_INDIRECT, opaddr_pkg::M_BIT_IND_REL: begin
        ea_base = ptr;
      end
      opaddr_pkg::M_REL_DIRECT: begin
        // Signed offset relative to the address after the instruction.
        ea_base = fetch_pc + {{8{arg[7]}}, arg};
      end
      opaddr_pkg::M_REL_INDIRECT: begin
        ea_base = fetch_pc + {{8{ptr[7]}}, ptr[7:0]};
      end
      default: begin
        ea_base = addr;
      end
    endcase
  end

  ea_adder u_add (
    .base      (ea_base),
    .index     (use_y ? y_index : x_index),
    .use_index (use_idx),
    .sum       (ea_sum)
  );

  // ===========================================================================
  // Fetch sequencer: opcode (after any prefix), operand bytes, pointer bytes.
  always_comb begin
    next_state     = state;
    next_fetch_pc  = fetch_pc;
    next_addr      = addr;
    next_ptr       = ptr;
    next_opc       = opc;
    next_arg       = arg;
    next_pfx       = pfx;
    next_nbytes    = nbytes;
    next_rst_pulse = 1'b0;
    case (state)
      S_IDLE: begin
        if (start) begin
          next_fetch_pc = pc;
          next_pfx      = 2'd0;
          next_nbytes   = 2'd0;
          next_state    = S_OPCODE;
        end
      end
      S_OPCODE: begin
        if (mem_ack) begin
          next_fetch_pc = fetch_pc + 16'h0001;
          if (is_prefix && pfx == 2'd0) begin
            if (mem_rdata == opaddr_pkg::Y_INDEX_PREFIX) begin
              next_pfx = 2'd1;
            end else if (mem_rdata == opaddr_pkg::INDIRECT_PREFIX) begin
              next_pfx = 2'd2;
            end else begin
              next_pfx = 2'd3;
            end
          end else begin
            next_opc   = mem_rdata;
            next_state = S_ARG1;
          end
        end
      end
      S_ARG1: begin
        if (!cls_legal) begin
          next_rst_pulse = 1'b1;
          next_state     = S_IDLE;
        end else if (eff_mode == opaddr_pkg::M_INHERENT ||
                     eff_mode == opaddr_pkg::M_IDX_NONE) begin
          next_state = S_FINISH;
        end else if (mem_ack) begin
          next_fetch_pc = fetch_pc + 16'h0001;
          next_nbytes   = 2'd1;
          next_arg      = mem_rdata;
          next_addr     = {8'h00, mem_rdata};
          if (eff_mode == opaddr_pkg::M_DIR_LONG ||
              eff_mode == opaddr_pkg::M_IDX_LONG) begin
            next_addr  = {mem_rdata, 8'h00};
            next_state = S_ARG2;
          end else if (eff_mode == opaddr_pkg::M_IND_SHORT ||
                       eff_mode == opaddr_pkg::M_INDIDX_SHORT ||
                       eff_mode == opaddr_pkg::M_REL_INDIRECT ||
                       eff_mode == opaddr_pkg::M_BIT_INDIRECT ||
                       eff_mode == opaddr_pkg::M_BIT_IND_REL) begin
            next_state = S_PTR_LO;
          end else if (eff_mode == opaddr_pkg::M_IND_LONG ||
                       eff_mode == opaddr_pkg::M_INDIDX_LONG) begin
            next_state = S_PTR_HI;
          end else begin
            next_state = S_FINISH;
          end
        end
      end
      S_ARG2: begin
        if (mem_ack) begin
          next_fetch_pc = fetch_pc + 16'h0001;
          next_nbytes   = 2'd2;
          next_addr     = {addr[15:8], mem_rdata};
          next_state    = S_FINISH;
        end
      end
      S_PTR_HI: begin
        if (mem_ack) begin
          next_ptr   = {mem_rdata, 8'h00};
          next_addr  = addr + 16'h0001;
          next_state = S_PTR_LO;
        end
      end
      S_PTR_LO: begin
        if (mem_ack) begin
          if (eff_mode == opaddr_pkg::M_IND_LONG ||
              eff_mode == opaddr_pkg::M_INDIDX_LONG) begin
            next_ptr = {ptr[15:8], mem_rdata};
          end else begin
            next_ptr = {8'h00, mem_rdata};
          end
          next_state = S_FINISH;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= S_IDLE;
      fetch_pc  <= opaddr_pkg::RESET_ADDR;
      addr      <= opaddr_pkg::RESET_ADDR;
      ptr       <= opaddr_pkg::RESET_ADDR;
      opc       <= opaddr_pkg::RESET_INDEX;
      arg       <= opaddr_pkg::RESET_INDEX;
      pfx       <= 2'd0;
      nbytes    <= 2'd0;
      rst_pulse <= 1'b0;
    end else begin
      state     <= next_state;
      fetch_pc  <= next_fetch_pc;
      addr      <= next_addr;
      ptr       <= next_ptr;
      opc       <= next_opc;
      arg       <= next_arg;
      pfx       <= next_pfx;
      nbytes    <= next_nbytes;
      rst_pulse <= next_rst_pulse;
    end
  end

  // ===========================================================================
  // Memory request: code bytes from the program counter, pointer bytes from
  // page zero at the address taken from the instruction.
  always_comb begin
    mem_req  = (state == S_OPCODE) || (state == S_ARG2) ||
               (state == S_PTR_HI) || (state == S_PTR_LO) ||
               (state == S_ARG1 && cls_legal &&
                eff_mode != opaddr_pkg::M_INHERENT &&
                eff_mode != opaddr_pkg::M_IDX_NONE);
    mem_addr = (state == S_PTR_HI || state == S_PTR_LO) ? addr : fetch_pc;
  end

  // ===========================================================================
  // Results, valid while done is high.
  always_comb begin
    done          = (state == S_FINISH);
    opcode        = opc;
    mode          = eff_mode;
    eff_addr      = ea_sum;
    operand       = arg;
    next_pc_out   = fetch_pc;
    operand_bytes = nbytes;
    illegal_reset = rst_pulse;
    case (eff_mode)
      opaddr_pkg::M_INHERENT:  mode_class = opaddr_pkg::CLS_INHERENT;
      opaddr_pkg::M_IMMEDIATE: mode_class = opaddr_pkg::CLS_IMMEDIATE;
      opaddr_pkg::M_DIR_SHORT,
      opaddr_pkg::M_DIR_LONG:  mode_class = opaddr_pkg::CLS_DIRECT;
      opaddr_pkg::M_IDX_NONE, opaddr_pkg::M_IDX_SHORT,
      opaddr_pkg::M_IDX_LONG:  mode_class = opaddr_pkg::CLS_INDEXED;
      opaddr_pkg::M_REL_DIRECT,
      opaddr_pkg::M_REL_INDIRECT: mode_class = opaddr_pkg::CLS_RELATIVE;
      opaddr_pkg::M_BIT_DIRECT, opaddr_pkg::M_BIT_INDIRECT,
      opaddr_pkg::M_BIT_DIR_REL,
      opaddr_pkg::M_BIT_IND_REL: mode_class = opaddr_pkg::CLS_BIT;
      default:                 mode_class = opaddr_pkg::CLS_INDIRECT;
    endcase
  end

endmodule
`default_nettype wire

// ### verilog/ea_adder.sv
// Effective address adder: base plus zero-extended index.
`timescale 1ns/1ps
`default_nettype none
module ea_adder (
  // Operands
  input  wire logic [15:0] base,
  input  wire logic [7:0]  index,
  input  wire logic        use_index,
  // Result
  output logic      [15:0] sum
);

  // Unsigned add with no wrap into page zero; short indexed reaches 1FE.
  always_comb begin
    sum = base + (use_index ? {8'h00, index} : 16'h0000);
  end

endmodule
`default_nettype wire

// ### verilog/opaddr_pkg.sv
// Package of constants and types for the operand address decoder.
package opaddr_pkg;

  // ===========================================================================
  // Prefix byte values
  localparam logic [7:0] Y_INDEX_PREFIX            = 8'h90;
  localparam logic [7:0] INDIRECT_PREFIX           = 8'h92;
  localparam logic [7:0] Y_INDIRECT_INDEXED_PREFIX = 8'h91;

  // ===========================================================================
  // Address space limit and reset values
  localparam logic [15:0] PAGE_ZERO_LAST = 16'h00ff;
  localparam logic [15:0] RESET_ADDR     = 16'h0000;
  localparam logic [7:0]  RESET_INDEX    = 8'h00;

  // ===========================================================================
  // Counts
  localparam int MODE_COUNT  = 17;
  localparam int CLASS_COUNT = 7;

  // Addressing mode classes.
  typedef enum logic [2:0] {
    CLS_INHERENT,
    CLS_IMMEDIATE,
    CLS_DIRECT,
    CLS_INDEXED,
    CLS_INDIRECT,
    CLS_RELATIVE,
    CLS_BIT
  } mode_class_e;

  // The full set of addressing modes.
  typedef enum logic [4:0] {
    M_INHERENT,
    M_IMMEDIATE,
    M_DIR_SHORT,
    M_DIR_LONG,
    M_IDX_NONE,
    M_IDX_SHORT,
    M_IDX_LONG,
    M_IND_SHORT,
    M_IND_LONG,
    M_INDIDX_SHORT,
    M_INDIDX_LONG,
    M_REL_DIRECT,
    M_REL_INDIRECT,
    M_BIT_DIRECT,
    M_BIT_INDIRECT,
    M_BIT_DIR_REL,
    M_BIT_IND_REL
  } addr_mode_e;

endpackage

// ### verilog/opcode_classifier.sv
// Opcode classifier: maps an opcode byte to its addressing mode.
`timescale 1ns/1ps
`default_nettype none
module opcode_classifier (
  // Opcode under decode
  input  wire logic [7:0]             opcode,
  // Classification
  output opaddr_pkg::addr_mode_e      mode,
  output logic                        rmw,
  output logic                        legal
);

  // ===========================================================================
  // Row decode on the high nibble; the low nibble only picks out the hole at 95.
  // Row 0/1 are bit ops, 2 is relative, 3-7 memory RMW/inherent, 8-9
  // inherent, A-F arithmetic with mode chosen by the row.
  always_comb begin
    mode  = opaddr_pkg::M_INHERENT;
    rmw   = 1'b0;
    legal = 1'b1;
    case (opcode[7:4])
      4'h0: begin
        mode = opaddr_pkg::M_BIT_DIR_REL;
      end
      4'h1: begin
        mode = opaddr_pkg::M_BIT_DIRECT;
      end
      4'h2: begin
        mode = opaddr_pkg::M_REL_DIRECT;
      end
      4'h3: begin
        mode = opaddr_pkg::M_DIR_SHORT;
        rmw  = 1'b1;
      end
      4'h6: begin
        mode = opaddr_pkg::M_IDX_SHORT;
        rmw  = 1'b1;
      end
      4'h7: begin
        mode = opaddr_pkg::M_IDX_NONE;
        rmw  = 1'b1;
      end
      4'h4, 4'h5, 4'h8, 4'h9: begin
        mode  = opaddr_pkg::M_INHERENT;
        // One hole in the inherent rows, 95, holds no instruction.
        legal = (opcode != 8'h95);
      end
      4'ha: begin
        mode = opaddr_pkg::M_IMMEDIATE;
      end
      4'hb: begin
        mode = opaddr_pkg::M_DIR_SHORT;
      end
      4'hc: begin
        mode = opaddr_pkg::M_DIR_LONG;
      end
      4'hd: begin
        mode = opaddr_pkg::M_IDX_LONG;
      end
      4'he: begin
        mode = opaddr_pkg::M_IDX_SHORT;
      end
      default: begin
        mode = opaddr_pkg::M_IDX_NONE;
      end
    endcase
  end

endmodule
`default_nettype wire
